// >>> dtc_pkg.sv
// Constants of the dual timer: register offsets, field positions, reset values.
// Assumes a 16-bit register port with a 4-bit word address.
//
// Contract
// [RL1] Timer A is a 16-bit up-counter: free-running or external event counter.
// [RL2] Timer A counts a prescaled clock picked by three bits, or the external clock.
// [RL3] Timer A overflow raises the overflow interrupt request.
// [RL4] Timer A match with a compare channel raises its interrupt, sets/resets outputs.
// [RL5] A valid trigger edge copies the timer A count into that channel.
// [RL6] A captured value holds until that channel's next capture trigger; a software write to the channel register replaces it too.
// [RL7] Both-edge trigger captures on every edge, for pulse width measurement.
// [RL8] Rising-edge trigger captures once per rising edge, for period measurement.
// [RL9] Timer B is a 16-bit interval up-counter on a prescaled clock, three bits.
// [RL10] Timer B equal to its compare clears the counter and raises match interrupt.
// [RL11] Timer B match interrupt can also start a DMA transfer.
// [RL12] After a match timer B returns to zero on the next count clock.
// [RL13] Matches are evaluated only right after a count-up.
// [RL14] Rewriting a compare register never signals a match by itself.
// [RL15] Clearing timer A externally gives no match against a zero channel.
// [RL16] Clearing timer B with compare zero is not a new match.
// [RL17] Free-running timer A wraps to zero on overflow and keeps counting.
// [RL18] Overflow flags clear by writing 0; writing 1 creates nothing.
// [RL19] Overflow during a status read is not seen until the next read.
// [RL20] Software sets a channel to compare before using it for the outputs.
// [RL21] External count clock, clear and trigger inputs are synchronised first.
package dtc_pkg;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int NUM_CH = 4;
   localparam int PRE_W = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Register word offsets
   localparam logic [3:0] OFS_TA_CONTROL = 4'h0;
   localparam logic [3:0] OFS_TA_COUNT = 4'h1;
   localparam logic [3:0] OFS_CHANNEL_0 = 4'h2;
   localparam logic [3:0] OFS_CHANNEL_CFG = 4'h6;
   localparam logic [3:0] OFS_OUT_CONTROL = 4'h7;
   localparam logic [3:0] OFS_TB_CONTROL = 4'h8;
   localparam logic [3:0] OFS_TB_COUNT = 4'h9;
   localparam logic [3:0] OFS_TB_COMPARE = 4'hA;
   localparam logic [3:0] OFS_OVF_STATUS = 4'hB;

   ////////////////////////////////////////////////////////////////////////////////
   // Timer A control fields
   localparam int TA_PRESCALE_SEL_LO = 0;
   localparam int TA_PRESCALE_SEL_HI = 1;
   localparam int TA_PRESCALE_MODE = 2;
   localparam int TA_EXT_CLOCK = 3;
   localparam int TA_RUN = 4;
   localparam int TA_CLEAR_EN = 5;
   localparam int TA_CTRL_W = 6;

   // Timer B control fields
   localparam int TB_PRESCALE_SEL = 0;
   localparam int TB_PRESCALE_MODE_LO = 1;
   localparam int TB_PRESCALE_MODE_HI = 2;
   localparam int TB_RUN = 3;
   localparam int TB_DMA_EN = 4;
   localparam int TB_CTRL_W = 5;

   // Channel config: compare select bits, then two edge bits per channel
   localparam int CFG_COMPARE_SEL = 0;
   localparam int CFG_EDGE_BASE = 4;
   localparam int CFG_W = 12;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Output control enables, one per timer output
   localparam int OUT_CTRL_W = 2;

   // Overflow status bit positions
   localparam int OVF_TA_BIT = 1;
   localparam int OVF_TB_BIT = 4;

   // Timer B divides by 32 at its lowest setting
   localparam int TB_PRESCALE_BASE = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [TA_CTRL_W-1:0] TA_CONTROL_RST = 6'h00;
   localparam logic [TB_CTRL_W-1:0] TB_CONTROL_RST = 5'h00;
   localparam logic [CFG_W-1:0] CHANNEL_CFG_RST = 12'h000;
   localparam logic [OUT_CTRL_W-1:0] OUT_CONTROL_RST = 2'h0;
   localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] COMPARE_RST = 16'hFFFF;
   localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF;

   // Tick when the low k+1 prescaler bits are all ones: divide by 2^(k+1)
   function automatic logic pre_tick(input logic [PRE_W-1:0] pre, input logic [2:0] k);
      logic [PRE_W-1:0] mask;
      mask = PRE_W'((16'h0002 << k) - 16'h0001);
      return &(pre | ~mask);
   endfunction
endpackage

// >>> dtc_edge_sync.sv
// Three-stage synchroniser with edge pulses for external pins.
// Assumes inputs are asynchronous to clk_in.
module dtc_edge_sync
   import dtc_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk_in, // System clock
   input wire logic rstn_in, // Async reset, active low
   input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
   output logic [WIDTH-1:0] level_out, // Accepted level
   output logic [WIDTH-1:0] rise_out, // One-cycle rising pulse
   output logic [WIDTH-1:0] fall_out // One-cycle falling pulse
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] sync_a;
   logic [WIDTH-1:0] sync_b;
   logic [WIDTH-1:0] stable;
   wire [WIDTH-1:0] agree;
   wire [WIDTH-1:0] next_stable;

   // Change accepted only when stages two and three agree
   assign agree = ~(sync_a ^ sync_b);
   assign next_stable = (agree & sync_b) | (~agree & stable);

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         meta <= '0;
         sync_a <= '0;
         sync_b <= '0;
         stable <= '0;
      end
      else
      begin
         meta <= pin_in; // see [RL21]
         sync_a <= meta;
         sync_b <= sync_a;
         stable <= next_stable;
      end
   end

   assign level_out = stable;
   assign rise_out = next_stable & ~stable;
   assign fall_out = ~next_stable & stable;
endmodule

// >>> dtc_timer.sv
// Dual 16-bit timer: capture/compare timer A and interval timer B.
// Assumes a single-cycle register port, read data valid one cycle after the strobe.
//
// Our own choices: the register addresses and the address-and-strobe port.
module dtc_timer
   import dtc_pkg::*;
#(
   parameter int CW = CNT_W
)
(
   input wire logic clk_in, // System clock, 100 MHz
   input wire logic rstn_in, // Async reset, active low
   input wire logic [ADDR_W-1:0] reg_addr_in, // Register word address
   input wire logic [DATA_W-1:0] reg_wdata_in, // Register write data
   input wire logic reg_wr_in, // Write strobe
   input wire logic reg_rd_in, // Read strobe
   output logic [DATA_W-1:0] reg_rdata_out, // Read data, cycle after strobe
   input wire logic ext_count_clock_in, // External count clock pin
   input wire logic ext_clear_start_in, // External clear pin
   input wire logic [NUM_CH-1:0] capture_trigger_in, // Capture trigger pins
   output logic timer_a_overflow_irq_out, // Timer A overflow pulse
   output logic [NUM_CH-1:0] channel_match_irq_out, // Channel match pulses
   output logic timer_out_0_out, // Timer output 0
   output logic timer_out_1_out, // Timer output 1
   output logic timer_b_match_irq_out, // Timer B match pulse
   output logic timer_b_dma_trigger_out // Timer B DMA start pulse
);
   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [PRE_W-1:0] pre_cnt;
   logic [TA_CTRL_W-1:0] timer_a_control;
   logic [TB_CTRL_W-1:0] timer_b_control;
   logic [CW-1:0] timer_a_count;
   logic [CW-1:0] timer_b_count;
   logic [CW-1:0] timer_b_compare;
   logic [CW-1:0] channel_reg [NUM_CH];
   logic [CFG_W-1:0] channel_cfg;
   logic [OUT_CTRL_W-1:0] out_control;
   logic timer_a_overflow_flag;
   logic timer_b_overflow_flag;
   logic [DATA_W-1:0] rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronised pins
   wire [NUM_CH+1:0] pin_rise;
   wire [NUM_CH+1:0] pin_fall;

   dtc_edge_sync #(
      .WIDTH(NUM_CH + 2)
   ) u_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .pin_in({capture_trigger_in, ext_clear_start_in, ext_count_clock_in}),
      .level_out(),
      .rise_out(pin_rise),
      .fall_out(pin_fall)
   );

   wire ext_clk_rise;
   wire ext_clr_rise;
   wire [NUM_CH-1:0] trig_rise;
   wire [NUM_CH-1:0] trig_fall;
   assign ext_clk_rise = pin_rise[0]; // see [RL21]
   assign ext_clr_rise = pin_rise[1]; // see [RL21]
   assign trig_rise = pin_rise[NUM_CH+1:2];
   assign trig_fall = pin_fall[NUM_CH+1:2];

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wr_ta_ctl;
   wire wr_tb_ctl;
   wire wr_tb_cmp;
   wire wr_cfg;
   wire wr_out;
   wire wr_ovf;
   wire [NUM_CH-1:0] wr_ch;
   assign wr_ta_ctl = reg_wr_in && (reg_addr_in == OFS_TA_CONTROL);
   assign wr_tb_ctl = reg_wr_in && (reg_addr_in == OFS_TB_CONTROL);
   assign wr_tb_cmp = reg_wr_in && (reg_addr_in == OFS_TB_COMPARE);
   assign wr_cfg = reg_wr_in && (reg_addr_in == OFS_CHANNEL_CFG);
   assign wr_out = reg_wr_in && (reg_addr_in == OFS_OUT_CONTROL);
   assign wr_ovf = reg_wr_in && (reg_addr_in == OFS_OVF_STATUS);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_wr
         assign wr_ch[gi] = reg_wr_in && (reg_addr_in == OFS_CHANNEL_0 + ADDR_W'(gi));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Timer A count clock
   wire [2:0] ta_sel;
   wire ta_run;
   wire ta_tick;
   wire ta_clear;
   wire [CW-1:0] ta_next;
   wire ta_wrap;
   assign ta_sel = {timer_a_control[TA_PRESCALE_MODE], timer_a_control[TA_PRESCALE_SEL_HI],
      timer_a_control[TA_PRESCALE_SEL_LO]}; // see [RL2]
   assign ta_run = timer_a_control[TA_RUN];
   assign ta_tick = ta_run && (timer_a_control[TA_EXT_CLOCK] ? ext_clk_rise
      : pre_tick(pre_cnt, ta_sel)); // see [RL1] [RL2]
   assign ta_clear = timer_a_control[TA_CLEAR_EN] && ext_clr_rise;
   assign ta_next = CW'(timer_a_count + CW'(1)); // see [RL17]
   assign ta_wrap = ta_tick && !ta_clear && (timer_a_count == COUNT_MAX); // see [RL3]

   ////////////////////////////////////////////////////////////////////////////////
   // Timer A channels
   wire [NUM_CH-1:0] compare_sel;
   wire [NUM_CH-1:0] ch_match;
   wire [NUM_CH-1:0] ch_capture;
   assign compare_sel = channel_cfg[CFG_COMPARE_SEL +: NUM_CH];

   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_ch
         wire [1:0] edge_mode;
         assign edge_mode = channel_cfg[CFG_EDGE_BASE + 2 * gi +: 2];
         // Match only on a count-up, never on a clear or a rewrite
         assign ch_match[gi] = compare_sel[gi] && ta_tick && !ta_clear
            && (ta_next == channel_reg[gi]); // see [RL4] [RL13] [RL14] [RL15]
         assign ch_capture[gi] = !compare_sel[gi]
            && ((trig_rise[gi] && (edge_mode == EDGE_RISE || edge_mode == EDGE_BOTH))
            || (trig_fall[gi] && (edge_mode == EDGE_FALL || edge_mode == EDGE_BOTH)));
         // see [RL5] [RL7] [RL8]
      end
   endgenerate

   // Channel 0 sets and 1 resets output 0; channel 2 sets and 3 resets output 1
   wire out0_set;
   wire out0_rst;
   wire out1_set;
   wire out1_rst;
   wire next_out0;
   wire next_out1;
   assign out0_set = out_control[0] && ch_match[0];
   assign out0_rst = out_control[0] && ch_match[1];
   assign out1_set = out_control[1] && ch_match[2];
   assign out1_rst = out_control[1] && ch_match[3];
   // Reset has priority over set
   assign next_out0 = out0_rst ? 1'b0 : (out0_set ? 1'b1 : timer_out_0_out); // see [RL4]
   assign next_out1 = out1_rst ? 1'b0 : (out1_set ? 1'b1 : timer_out_1_out); // see [RL20]

   ////////////////////////////////////////////////////////////////////////////////
   // Timer B
   wire [2:0] tb_sel;
   wire tb_tick;
   wire tb_at_cmp;
   wire [CW-1:0] tb_next;
   wire tb_match;
   wire tb_wrap;
   wire [2:0] tb_div;
   assign tb_sel = {timer_b_control[TB_PRESCALE_MODE_HI], timer_b_control[TB_PRESCALE_MODE_LO],
      timer_b_control[TB_PRESCALE_SEL]};
   assign tb_div = 3'(TB_PRESCALE_BASE) + {1'b0, tb_sel[1:0]};
   // Mode high bit fixes the divider at 256, the same as the top low setting
   assign tb_tick = timer_b_control[TB_RUN]
      && pre_tick(pre_cnt, tb_sel[2] ? 3'h7 : tb_div); // see [RL9]
   assign tb_at_cmp = (timer_b_count == timer_b_compare);
   assign tb_next = CW'(timer_b_count + CW'(1));
   // Counter sitting on compare is cleared, not re-matched
   assign tb_match = tb_tick && !tb_at_cmp
      && (tb_next == timer_b_compare); // see [RL10] [RL13] [RL14] [RL16]
   assign tb_wrap = tb_tick && !tb_at_cmp && (timer_b_count == COUNT_MAX);

   ////////////////////////////////////////////////////////////////////////////////
   // Overflow flags: set wins over a software clear
   wire next_ta_ovf;
   wire next_tb_ovf;
   assign next_ta_ovf = ta_wrap
      || (timer_a_overflow_flag && !(wr_ovf && !reg_wdata_in[OVF_TA_BIT])); // see [RL18]
   assign next_tb_ovf = tb_wrap
      || (timer_b_overflow_flag && !(wr_ovf && !reg_wdata_in[OVF_TB_BIT])); // see [RL18]

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux
   logic [DATA_W-1:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      case (reg_addr_in)
         OFS_TA_CONTROL: rd_mux = DATA_W'(timer_a_control);
         OFS_TA_COUNT: rd_mux = DATA_W'(timer_a_count);
         OFS_CHANNEL_0: rd_mux = DATA_W'(channel_reg[0]);
         OFS_CHANNEL_0 + 4'h1: rd_mux = DATA_W'(channel_reg[1]);
         OFS_CHANNEL_0 + 4'h2: rd_mux = DATA_W'(channel_reg[2]);
         OFS_CHANNEL_0 + 4'h3: rd_mux = DATA_W'(channel_reg[3]);
         OFS_CHANNEL_CFG: rd_mux = DATA_W'(channel_cfg);
         OFS_OUT_CONTROL: rd_mux = DATA_W'(out_control);
         OFS_TB_CONTROL: rd_mux = DATA_W'(timer_b_control);
         OFS_TB_COUNT: rd_mux = DATA_W'(timer_b_count);
         OFS_TB_COMPARE: rd_mux = DATA_W'(timer_b_compare);
         OFS_OVF_STATUS:
         begin
            // Value frozen at the strobe; a same-cycle overflow shows next read
            rd_mux[OVF_TA_BIT] = timer_a_overflow_flag; // see [RL19]
            rd_mux[OVF_TB_BIT] = timer_b_overflow_flag; // see [RL19]
         end
         default: rd_mux = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control and status registers
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         pre_cnt <= '0;
         timer_a_control <= TA_CONTROL_RST;
         timer_b_control <= TB_CONTROL_RST;
         channel_cfg <= CHANNEL_CFG_RST;
         out_control <= OUT_CONTROL_RST;
         timer_a_overflow_flag <= 1'b0;
         timer_b_overflow_flag <= 1'b0;
         rdata <= '0;
      end
      else
      begin
         pre_cnt <= PRE_W'(pre_cnt + PRE_W'(1));
         if (wr_ta_ctl)
            timer_a_control <= reg_wdata_in[TA_CTRL_W-1:0];
         if (wr_tb_ctl)
            timer_b_control <= reg_wdata_in[TB_CTRL_W-1:0];
         if (wr_cfg)
            channel_cfg <= reg_wdata_in[CFG_W-1:0];
         if (wr_out)
            out_control <= reg_wdata_in[OUT_CTRL_W-1:0];
         timer_a_overflow_flag <= next_ta_ovf;
         timer_b_overflow_flag <= next_tb_ovf;
         rdata <= reg_rd_in ? rd_mux : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timer A counter
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         timer_a_count <= COUNT_RST;
      else if (ta_clear)
         timer_a_count <= COUNT_RST; // see [RL15]
      else if (ta_tick)
         timer_a_count <= ta_next; // see [RL1] [RL17]
   end

   // Channel registers: a capture beats a software write
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_chreg
         always_ff @(posedge clk_in or negedge rstn_in)
         begin
            if (!rstn_in)
               channel_reg[gi] <= COMPARE_RST;
            else if (ch_capture[gi])
               channel_reg[gi] <= timer_a_count; // see [RL5] [RL6]
            else if (wr_ch[gi])
               channel_reg[gi] <= reg_wdata_in[CW-1:0];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Timer B counter and compare
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         timer_b_count <= COUNT_RST;
         timer_b_compare <= COMPARE_RST;
      end
      else
      begin
         if (tb_tick)
            timer_b_count <= tb_at_cmp ? COUNT_RST : tb_next; // see [RL12]
         if (wr_tb_cmp)
            timer_b_compare <= reg_wdata_in[CW-1:0]; // see [RL14]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         timer_a_overflow_irq_out <= 1'b0;
         channel_match_irq_out <= '0;
         timer_out_0_out <= 1'b0;
         timer_out_1_out <= 1'b0;
         timer_b_match_irq_out <= 1'b0;
         timer_b_dma_trigger_out <= 1'b0;
      end
      else
      begin
         timer_a_overflow_irq_out <= ta_wrap; // see [RL3]
         channel_match_irq_out <= ch_match; // see [RL4]
         timer_out_0_out <= next_out0;
         timer_out_1_out <= next_out1;
         timer_b_match_irq_out <= tb_match; // see [RL10]
         timer_b_dma_trigger_out <= tb_match && timer_b_control[TB_DMA_EN]; // see [RL11]
      end
   end

   assign reg_rdata_out = rdata;
endmodule

// >>> dtc_timer_asserts.sv
// Port-level checker of the dual timer.
// Assumes it is bound into dtc_timer and sees only that module's ports.
module dtc_timer_chk
   import dtc_pkg::*;
#(
   parameter int CW = CNT_W
)
(
   input wire logic clk_in, // System clock
   input wire logic rstn_in, // Async reset, active low
   input wire logic reg_rd_in, // Read strobe
   input wire logic [DATA_W-1:0] reg_rdata_out, // Read data
   input wire logic timer_a_overflow_irq_out, // Overflow pulse
   input wire logic [NUM_CH-1:0] channel_match_irq_out, // Match pulses
   input wire logic timer_out_0_out, // Output 0
   input wire logic timer_out_1_out, // Output 1
   input wire logic timer_b_match_irq_out, // Timer B match
   input wire logic timer_b_dma_trigger_out // DMA start
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   ////////////////////////////////////////////////////////////////////////////////
   // No pulse can come before any count-up has happened
   sequence s_quiet;
      !timer_a_overflow_irq_out && channel_match_irq_out == '0 && !timer_b_match_irq_out;
   endsequence
   sequence s_tb_match;
      timer_b_match_irq_out;
   endsequence

   property p_reset_quiet;
      $rose(rstn_in) |-> s_quiet ##1 s_quiet;
   endproperty
   property p_rdata_idle;
      !reg_rd_in |=> reg_rdata_out == '0;
   endproperty
   property p_ovf_pulse;
      timer_a_overflow_irq_out |=> !timer_a_overflow_irq_out;
   endproperty
   property p_match_pulse;
      (channel_match_irq_out & $past(channel_match_irq_out)) == '0;
   endproperty
   property p_out0_set;
      $rose(timer_out_0_out) |-> channel_match_irq_out[0] && !channel_match_irq_out[1];
   endproperty
   property p_out0_clr;
      $fell(timer_out_0_out) |-> channel_match_irq_out[1];
   endproperty
   property p_out1_set;
      $rose(timer_out_1_out) |-> channel_match_irq_out[2] && !channel_match_irq_out[3];
   endproperty
   property p_out1_clr;
      $fell(timer_out_1_out) |-> channel_match_irq_out[3];
   endproperty
   property p_dma;
      timer_b_dma_trigger_out |-> timer_b_match_irq_out;
   endproperty
   property p_tb_gap;
      s_tb_match |=> (!timer_b_match_irq_out) [*8];
   endproperty

   a_reset_quiet: assert property (p_reset_quiet) else $error("pulse right after reset");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
   a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse too long");
   a_match_pulse: assert property (p_match_pulse) else $error("match pulse too long");
   a_out0_set: assert property (p_out0_set) else $error("output 0 set without match");
   a_out0_clr: assert property (p_out0_clr) else $error("output 0 reset without match");
   a_out1_set: assert property (p_out1_set) else $error("output 1 set without match");
   a_out1_clr: assert property (p_out1_clr) else $error("output 1 reset without match");
   a_dma: assert property (p_dma) else $error("DMA start without match");
   a_tb_gap: assert property (p_tb_gap) else $error("timer B matches too close");
endmodule

bind dtc_timer dtc_timer_chk #(.CW(CW)) u_dtc_timer_chk (.clk_in(clk_in), .rstn_in(rstn_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .timer_a_overflow_irq_out(timer_a_overflow_irq_out),
   .channel_match_irq_out(channel_match_irq_out), .timer_out_0_out(timer_out_0_out),
   .timer_out_1_out(timer_out_1_out), .timer_b_match_irq_out(timer_b_match_irq_out),
   .timer_b_dma_trigger_out(timer_b_dma_trigger_out));

// >>> dtc_pins.sv
// Model of the external pins: count clock, clear and capture triggers.
// Assumes the timer synchronises the pins itself.
module dtc_pins
   import dtc_pkg::*;
(
   input wire logic clk_in, // System clock
   output logic count_clock_out, // Count clock pin
   output logic clear_out, // Clear pin
   output logic [NUM_CH-1:0] trigger_out // Trigger pins
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      count_clock_out = 1'b0;
      clear_out = 1'b0;
      trigger_out = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Each level held long enough to pass the synchroniser
   task automatic tick(input int gap);
      @(posedge clk_in);
      count_clock_out <= !count_clock_out;
      repeat (4) @(posedge clk_in);
      count_clock_out <= !count_clock_out;
      repeat (5 + gap) @(posedge clk_in);
   endtask

   task automatic clear();
      @(posedge clk_in);
      clear_out <= !clear_out;
      repeat (4) @(posedge clk_in);
      clear_out <= !clear_out;
      repeat (6) @(posedge clk_in);
   endtask

   task automatic trig(input logic [NUM_CH-1:0] v);
      @(posedge clk_in);
      trigger_out <= v;
      repeat (8) @(posedge clk_in);
   endtask
endmodule

// >>> testbench.sv
// Self-checking bench of the dual timer against expected values computed inline.
// Assumes dtc_pkg, dtc_timer, dtc_pins and the checker are compiled first.
module testbench
   import dtc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [ADDR_W-1:0] reg_addr_in = '0;
   logic [DATA_W-1:0] reg_wdata_in = '0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [DATA_W-1:0] reg_rdata_out, rv;
   logic ext_count_clock_in, ext_clear_start_in;
   logic [NUM_CH-1:0] capture_trigger_in, channel_match_irq_out;
   logic timer_a_overflow_irq_out, timer_out_0_out, timer_out_1_out;
   logic timer_b_match_irq_out, timer_b_dma_trigger_out;
   int failures = 0;
   int n_tests = 0;
   int seed = 22;
   int hits [NUM_CH] = '{0, 0, 0, 0};
   int ovf_hits = 0;
   int n, t, cnt;
   int intervals [$];

   always #5 clk_in = ~clk_in;

   dtc_timer u_dtc_timer (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .ext_count_clock_in(ext_count_clock_in),
      .ext_clear_start_in(ext_clear_start_in), .capture_trigger_in(capture_trigger_in),
      .timer_a_overflow_irq_out(timer_a_overflow_irq_out),
      .channel_match_irq_out(channel_match_irq_out), .timer_out_0_out(timer_out_0_out),
      .timer_out_1_out(timer_out_1_out), .timer_b_match_irq_out(timer_b_match_irq_out),
      .timer_b_dma_trigger_out(timer_b_dma_trigger_out));

   dtc_pins u_dtc_pins (.clk_in(clk_in), .count_clock_out(ext_count_clock_in),
      .clear_out(ext_clear_start_in), .trigger_out(capture_trigger_in));

   always @(posedge clk_in)
   begin
      for (int i = 0; i < NUM_CH; i++)
         if (channel_match_irq_out[i] === 1'b1) hits[i] <= hits[i] + 1;
      if (timer_a_overflow_irq_out === 1'b1) ovf_hits <= ovf_hits + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 check(reg_rdata_out, exp);
   endtask

   // Cycles until the next timer B match, bounded
   task automatic wait_tb(output int c);
      c = 0;
      do
      begin
         @(posedge clk_in);
         c++;
         if (c > 5000)
         begin
            failures++;
            $display("[FAIL] %0t timer B match missing", $time);
            end_of_test();
         end
      end
      while (timer_b_match_irq_out !== 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clk_in);
      rstn_in <= 1'b1;
      wr(4'hC, 16'h5555);
      wr(OFS_TA_COUNT, 16'h1234);
      wr(OFS_OVF_STATUS, 16'h0012);
      for (int a = 0; a < 16; a++)
         rd(ADDR_W'(a), ((a >= 2 && a <= 5) || a == 10) ? 16'hFFFF : 16'h0000);
      // Timer B: each divider from 32 to 256 (settings 0 to 4), compare 3, DMA on
      wr(OFS_TB_COMPARE, 16'h0003);
      for (int k = 0; k < 5; k++)
      begin
         wr(OFS_TB_CONTROL, (k == 4) ? 16'h001C : DATA_W'(16'h0018 | k));
         wait_tb(t);
         wait_tb(t);
         wait_tb(t);
         intervals.push_back(4 * ((k == 4) ? 256 : (32 << k)));
         check(DATA_W'(t), DATA_W'(intervals[k]));
         check(DATA_W'(timer_b_dma_trigger_out), 16'h0001);
      end
      wr(OFS_TB_CONTROL, 16'h0000);
      // Timer A as event counter with clear enabled
      wr(OFS_TA_CONTROL, 16'h0038);
      n = ($unsigned($random(seed)) % 16) + 1;
      for (int i = 0; i < n; i++)
         u_dtc_pins.tick($unsigned($random(seed)) % 4);
      rd(OFS_TA_COUNT, DATA_W'(n));
      wr(OFS_OUT_CONTROL, 16'h0001);
      wr(OFS_CHANNEL_0, DATA_W'(n + 2));
      wr(4'h3, DATA_W'(n + 3));
      wr(4'h4, DATA_W'(n));
      wr(OFS_CHANNEL_CFG, 16'h0007);
      repeat (10) @(posedge clk_in);
      check(DATA_W'(hits[2]), 16'h0000);
      u_dtc_pins.tick(0);
      u_dtc_pins.tick(0);
      check(DATA_W'(hits[0]), 16'h0001);
      check(DATA_W'(timer_out_0_out), 16'h0001);
      u_dtc_pins.tick(0);
      check(DATA_W'(hits[1]), 16'h0001);
      check(DATA_W'(timer_out_0_out), 16'h0000);
      // Channel 2 sets output 1 on the next count
      wr(4'h4, DATA_W'(n + 4));
      wr(OFS_OUT_CONTROL, 16'h0003);
      u_dtc_pins.tick(0);
      check(DATA_W'(timer_out_1_out), 16'h0001);
      wr(OFS_CHANNEL_0, 16'h0000);
      u_dtc_pins.clear();
      rd(OFS_TA_COUNT, 16'h0000);
      check(DATA_W'(hits[0]), 16'h0001);
      // Capture: channel 2 rising edge, channel 3 both edges
      wr(OFS_CHANNEL_CFG, 16'h0D03);
      cnt = 0;
      repeat (5) u_dtc_pins.tick(0);
      cnt += 5;
      u_dtc_pins.trig(4'b1100);
      rd(4'h4, DATA_W'(cnt));
      rd(4'h5, DATA_W'(cnt));
      repeat (3) u_dtc_pins.tick(0);
      u_dtc_pins.trig(4'b0000);
      rd(4'h4, DATA_W'(cnt));
      rd(4'h5, DATA_W'(cnt + 3));
      u_dtc_pins.tick(1);
      u_dtc_pins.trig(4'b0100);
      rd(4'h4, DATA_W'(cnt + 4));
      rd(4'h5, DATA_W'(cnt + 3));
      check(DATA_W'(ovf_hits), 16'h0000);
      end_of_test();
   end
endmodule
